// >>> rtl/ppac_top.sv
// top: prescalers, alignment and concatenation controls of an eight-channel pwm unit
// Functional notes
// - Bits 6..4 of the prescaler register pick the divide rate of shared clock B.
// - Bits 2..0 of the prescaler register pick the divide rate of shared clock A.
// - A field value n gives the bus clock divided by 2**n, from 1 up to 128.
// - A set alignment bit makes its channel center aligned, a clear one left aligned.
// - Alignment bits of absent channels ignore writes and read as zero.
// - Four concatenation bits join channel pairs; bits of absent pairs ignore writes, read 0.
// - In a joined pair the even channel supplies the high-order byte.
`timescale 1ns/1ps
module ppac_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic clock_a_tick,
  output logic clock_b_tick,
  output logic [7:0] center_align_bit,
  output logic [3:0] concat_en,
  output logic [7:0] chan_high_byte,
  output logic [7:0] chan_low_byte
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // async assert, release through two flops so no flop sees a late edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // state and field views
  // ----------------------------------------------------------------
  ppac_pkg::ppac_state_t state_reg;
  ppac_pkg::ppac_state_t state_next;
  logic [ppac_pkg::SEL_W-1:0] clock_a_divide_sel;
  logic [ppac_pkg::SEL_W-1:0] clock_b_divide_sel;
  logic tick_a_w;
  logic tick_b_w;
  logic [7:0] high_byte_w;
  logic [7:0] low_byte_w;

  assign clock_b_divide_sel = state_reg.prescaler_select[ppac_pkg::CLOCK_B_SEL_LSB +: 3];
  assign clock_a_divide_sel = state_reg.prescaler_select[ppac_pkg::CLOCK_A_SEL_LSB +: 3];

  // ----------------------------------------------------------------
  // two taps on one shared counter
  // ----------------------------------------------------------------
  // one counter for both clocks keeps a and b phase locked to each other
  ppac_prescaler u_div_a (
    .count(state_reg.div_cnt),
    .divide_sel(clock_a_divide_sel),
    .tick(tick_a_w)
  );

  ppac_prescaler u_div_b (
    .count(state_reg.div_cnt),
    .divide_sel(clock_b_divide_sel),
    .tick(tick_b_w)
  );

  // ----------------------------------------------------------------
  // byte roles of each channel in a joined pair
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < ppac_pkg::NUM_PAIRS; k++) begin : g_pair
      assign high_byte_w[2*k] = state_reg.concat[k];
      assign high_byte_w[2*k+1] = 1'b0;
      assign low_byte_w[2*k] = 1'b0;
      assign low_byte_w[2*k+1] = state_reg.concat[k];
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      state_next.div_cnt = state_reg.div_cnt + 7'h01;
      state_next.tick_a = tick_a_w;
      state_next.tick_b = tick_b_w;
      state_next.high_byte = high_byte_w;
      state_next.low_byte = low_byte_w;
      state_next.rdata = 8'h00;
      // register writes; masked bits stay zero whatever is written
      if (wr) begin
        case (addr)
          ppac_pkg::ADDR_PRESCALER_SELECT: begin
            state_next.prescaler_select = wdata & ppac_pkg::PRESCALER_WR_MASK;
          end
          ppac_pkg::ADDR_CENTER_ALIGN_SELECT: begin
            state_next.center_align_select = wdata & ppac_pkg::CHAN_PRESENT;
          end
          ppac_pkg::ADDR_PWM_CONTROL: begin
            state_next.concat = wdata[ppac_pkg::CONCAT_LSB +: 4] & ppac_pkg::PAIR_PRESENT;
          end
          default: begin
          end
        endcase
      end
      // reads answer one cycle later; unmapped offsets read zero
      if (rd) begin
        case (addr)
          ppac_pkg::ADDR_PRESCALER_SELECT: begin
            state_next.rdata = state_reg.prescaler_select;
          end
          ppac_pkg::ADDR_CENTER_ALIGN_SELECT: begin
            state_next.rdata = state_reg.center_align_select;
          end
          ppac_pkg::ADDR_PWM_CONTROL: begin
            state_next.rdata = {state_reg.concat, 4'h0};
          end
          default: begin
            state_next.rdata = 8'h00;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.prescaler_select <= ppac_pkg::PRESCALER_SELECT_RST;
      state_reg.center_align_select <= ppac_pkg::CENTER_ALIGN_SELECT_RST;
      state_reg.concat <= ppac_pkg::CONCAT_RST;
      state_reg.div_cnt <= 7'h00;
      state_reg.tick_a <= 1'b0;
      state_reg.tick_b <= 1'b0;
      state_reg.rdata <= 8'h00;
      state_reg.high_byte <= 8'h00;
      state_reg.low_byte <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign rdata = state_reg.rdata;
  assign clock_a_tick = state_reg.tick_a;
  assign clock_b_tick = state_reg.tick_b;
  assign center_align_bit = state_reg.center_align_select;
  assign concat_en = state_reg.concat;
  assign chan_high_byte = state_reg.high_byte;
  assign chan_low_byte = state_reg.low_byte;

  // ----------------------------------------------------------------
  // checking helpers: spacing of clock a ticks
  // ----------------------------------------------------------------
  logic [7:0] gap_reg;
  logic seen_reg;
  logic [2:0] used_sel_reg;

  // a period only counts if the select held steady across all of it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 8'h00;
      seen_reg <= 1'b0;
      used_sel_reg <= 3'h0;
    end else if (ce) begin
      used_sel_reg <= clock_a_divide_sel;
      if (state_reg.tick_a) begin
        gap_reg <= 8'h00;
        seen_reg <= (clock_a_divide_sel == used_sel_reg);
      end else begin
        gap_reg <= gap_reg + 8'h01;
        if (clock_a_divide_sel != used_sel_reg) begin
          seen_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_prescale;
    ce && wr && (addr == ppac_pkg::ADDR_PRESCALER_SELECT);
  endsequence

  sequence s_wr_center;
    ce && wr && (addr == ppac_pkg::ADDR_CENTER_ALIGN_SELECT);
  endsequence

  sequence s_wr_control;
    ce && wr && (addr == ppac_pkg::ADDR_PWM_CONTROL);
  endsequence

  sequence s_rd_center;
    ce && rd && (addr == ppac_pkg::ADDR_CENTER_ALIGN_SELECT);
  endsequence

  a_clk_b_sel: assert property (s_wr_prescale |=> clock_b_divide_sel == $past(wdata[6:4]))
    else $error("clock b select not taken from write");

  a_clk_a_sel: assert property (s_wr_prescale |=> clock_a_divide_sel == $past(wdata[2:0]))
    else $error("clock a select not taken from write");

  a_tick_a_period: assert property ((ce && state_reg.tick_a && seen_reg) |->
    gap_reg == 8'((8'h01 << used_sel_reg) - 8'h01))
    else $error("clock a tick spacing is not 2**n");

  a_tick_b_every: assert property ((clock_b_divide_sel == 3'h0) ##1
    (ce && clock_b_divide_sel == 3'h0) |=> clock_b_tick)
    else $error("undivided clock b missed a cycle");

  a_align_write: assert property (s_wr_center |=>
    center_align_bit == ($past(wdata) & ppac_pkg::CHAN_PRESENT))
    else $error("alignment bits not taken from write");

  a_align_absent: assert property ((center_align_bit & ~ppac_pkg::CHAN_PRESENT) == 8'h00)
    else $error("absent channel alignment bit set");

  a_concat_write: assert property (s_wr_control |=>
    concat_en == ($past(wdata[7:4]) & ppac_pkg::PAIR_PRESENT))
    else $error("concatenation bits not taken from write");

  a_concat_read: assert property ((ce && rd && addr == ppac_pkg::ADDR_PWM_CONTROL) |=>
    rdata == {$past(concat_en), 4'h0})
    else $error("control read does not show concatenation bits");

  // no write in the sampled cycle, so the byte roles and the control bits come from one value
  a_high_byte_even: assert property ((ce && !wr) |=>
    chan_high_byte == {1'b0, concat_en[3], 1'b0, concat_en[2],
                       1'b0, concat_en[1], 1'b0, concat_en[0]})
    else $error("high byte not on even channel of joined pair");

  a_align_read: assert property (s_rd_center |=> rdata == $past(center_align_bit))
    else $error("alignment read returns wrong value");

  a_rdata_idle: assert property ((ce && !rd) |=> rdata == 8'h00)
    else $error("read data not zero outside read answer");

endmodule : ppac_top

// >>> rtl/ppac_pkg.sv
// package: register map, field layout, reset values and state type of the pwm config core
package ppac_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 8;
  localparam int NUM_PAIRS = 4;
  localparam int SEL_W = 3;
  localparam int CNT_W = 7;   // enough for the largest divide, 2**7

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PRESCALER_SELECT = 8'h03;
  localparam logic [7:0] ADDR_CENTER_ALIGN_SELECT = 8'h04;
  localparam logic [7:0] ADDR_PWM_CONTROL = 8'h05;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLOCK_B_SEL_LSB = 4;
  localparam int CLOCK_A_SEL_LSB = 0;
  localparam int CONCAT_LSB = 4;   // pair 0/1 at bit 4 .. pair 6/7 at bit 7

  // ----------------------------------------------------------------
  // writable masks and implemented channels
  // ----------------------------------------------------------------
  localparam logic [7:0] PRESCALER_WR_MASK = 8'h77;
  localparam logic [7:0] CHAN_PRESENT = 8'hFF;
  localparam logic [3:0] PAIR_PRESENT = 4'hF;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PRESCALER_SELECT_RST = 8'h00;
  localparam logic [7:0] CENTER_ALIGN_SELECT_RST = 8'h00;
  localparam logic [3:0] CONCAT_RST = 4'h0;

  // ----------------------------------------------------------------
  // state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prescaler_select;
    logic [7:0] center_align_select;
    logic [3:0] concat;
    logic [CNT_W-1:0] div_cnt;
    logic tick_a;
    logic tick_b;
    logic [7:0] rdata;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } ppac_state_t;

endpackage : ppac_pkg

// >>> rtl/ppac_prescaler.sv
// prescaler tap: marks the cycles where the shared counter ends a 2**n period
`timescale 1ns/1ps
module ppac_prescaler (
  input wire logic [ppac_pkg::CNT_W-1:0] count,
  input wire logic [ppac_pkg::SEL_W-1:0] divide_sel,
  output logic tick
);

  logic [ppac_pkg::CNT_W-1:0] mask;

  // ----------------------------------------------------------------
  // low n bits of the mask set, n = divide_sel
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < ppac_pkg::CNT_W; i++) begin : g_mask
      assign mask[i] = (i < divide_sel);
    end
  endgenerate

  // n = 0 gives an empty mask, so every cycle ticks
  assign tick = ((count & mask) == mask);

endmodule : ppac_prescaler

// >>> dv/ppac_top_tb.sv
// testbench: register access, prescaler rates, alignment and concatenation controls
`timescale 1ns/1ps
module ppac_top_tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic clock_a_tick;
  logic clock_b_tick;
  logic [7:0] center_align_bit;
  logic [3:0] concat_en;
  logic [7:0] chan_high_byte;
  logic [7:0] chan_low_byte;
  int mismatches = 0;
  int cmp_count = 0;

  ppac_top ppac_top_inst (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .clock_a_tick(clock_a_tick),
    .clock_b_tick(clock_b_tick),
    .center_align_bit(center_align_bit),
    .concat_en(concat_en),
    .chan_high_byte(chan_high_byte),
    .chan_low_byte(chan_low_byte)
  );

  // 100 mhz bus clock
  initial begin
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // one-cycle write; a gap cycle follows so the strobe never gets two drivers at one edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe, then fall back to zero
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, exp});
    @(posedge clock);
    #1;
    check({8'h00, rdata}, 16'h0000);
  endtask : rd_reg

  // counts tick cycles over 256 cycles; any 2**n period divides that window exactly
  task automatic tick_rate(input logic [2:0] na, input logic [2:0] nb);
    int ca;
    int cb;
    ca = 0;
    cb = 0;
    wr_reg(ppac_pkg::ADDR_PRESCALER_SELECT, {1'b0, nb, 1'b0, na});
    repeat (4) @(posedge clock);
    repeat (256) begin
      @(posedge clock);
      #1;
      ca += int'(clock_a_tick === 1'b1);
      cb += int'(clock_b_tick === 1'b1);
    end
    check(16'(ca), 16'(256 >> na));
    check(16'(cb), 16'(256 >> nb));
  endtask : tick_rate

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    // reset values of all three registers
    rd_reg(ppac_pkg::ADDR_PRESCALER_SELECT, 8'h00);
    rd_reg(ppac_pkg::ADDR_CENTER_ALIGN_SELECT, 8'h00);
    rd_reg(ppac_pkg::ADDR_PWM_CONTROL, 8'h00);
    // alignment per channel, channels idle meanwhile
    wr_reg(ppac_pkg::ADDR_CENTER_ALIGN_SELECT, 8'hA5);
    #1;
    check({8'h00, center_align_bit}, 16'h00A5);
    rd_reg(ppac_pkg::ADDR_CENTER_ALIGN_SELECT, 8'hA5);
    wr_reg(ppac_pkg::ADDR_CENTER_ALIGN_SELECT, 8'h5A);
    #1;
    check({8'h00, center_align_bit}, 16'h005A);
    // reserved prescaler bits 7 and 3 stay zero
    wr_reg(ppac_pkg::ADDR_PRESCALER_SELECT, 8'hFF);
    rd_reg(ppac_pkg::ADDR_PRESCALER_SELECT, 8'h77);
    // every select value on both clocks
    for (int n = 0; n < 8; n++) begin
      tick_rate(3'(n), 3'(7 - n));
    end
    // each pair joined alone: even channel takes the high byte
    for (int k = 0; k < 4; k++) begin
      wr_reg(ppac_pkg::ADDR_PWM_CONTROL, 8'(1 << (4 + k)));
      @(posedge clock);
      #1;
      check({12'h000, concat_en}, 16'(1 << k));
      check({8'h00, chan_high_byte}, 16'(1 << (2 * k)));
      check({8'h00, chan_low_byte}, 16'(2 << (2 * k)));
    end
    // all bits written: low nibble reserved
    wr_reg(ppac_pkg::ADDR_PWM_CONTROL, 8'hFF);
    @(posedge clock);
    #1;
    check({chan_high_byte, chan_low_byte}, 16'h55AA);
    rd_reg(ppac_pkg::ADDR_PWM_CONTROL, 8'hF0);
    // unmapped address: write ignored, read zero
    wr_reg(8'h10, 8'h3C);
    rd_reg(8'h10, 8'h00);
    rd_reg(ppac_pkg::ADDR_CENTER_ALIGN_SELECT, 8'h5A);
    // write with clock enable low is ignored
    @(posedge clock);
    ce <= 1'b0;
    wr_reg(ppac_pkg::ADDR_CENTER_ALIGN_SELECT, 8'h00);
    @(posedge clock);
    ce <= 1'b1;
    rd_reg(ppac_pkg::ADDR_CENTER_ALIGN_SELECT, 8'h5A);
    // reset in mid-run clears everything
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check({center_align_bit, 4'h0, concat_en}, 16'h0000);
    rd_reg(ppac_pkg::ADDR_PRESCALER_SELECT, 8'h00);
    test_done();
  end

  // watchdog: the sequence needs about 2200 cycles
  initial begin
    #500000;
    mismatches++;
    test_done();
  end
endmodule : ppac_top_tb
